// ===== core/clock_gen_power_control.sv
// clock source selection, system pll control, clock gating and power modes
// Functional notes
// - reset runs from 12 MHz internal RC oscillator
// - RC oscillator feeds watchdog timer and PLL
// - crystal oscillator drives core directly or via PLL
// - watchdog oscillator drives core, watchdog, clock output
// - PLL multiplier programmable 1 to 32
// - loop divider keeps oscillator in 156-320 MHz
// - post divider ratios 2, 4, 8, 16
// - PLL output always 50 % duty
// - reset powers PLL off and bypasses it
// - PLL settles 100 us before lock
// - clock output selects RC, crystal, watchdog, main
// - Deep power-down wake restarts on RC oscillator
// - three reduced power states implemented
// - core clock divider programmable at run time
// - per-peripheral clock enables stop clocks fully
// - selected peripherals get own clock divider
// - Sleep stops only the core clock
// - 32 kHz oscillator feeds only the RTC
`timescale 1ns/1ps
module clock_gen_power_control
  import clkpwr_pkg::*;
#(
  parameter int N_PERIPH = 16,
  parameter int N_PDIV   = 2,
  parameter int LOCK_CYC = PLL_SETTLE_CYC
) (
  input  wire logic                mclk_i,
  input  wire logic                srst_i,
  input  wire logic [7:0]          addr_i,
  input  wire logic [31:0]         wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [31:0]         rdata_o,
  input  wire logic                irc_osc_i,
  input  wire logic                sys_osc_i,
  input  wire logic                wdo_osc_i,
  input  wire logic                rtc_osc_i,
  input  wire logic                cco_osc_i,
  input  wire logic                wake_i,
  output logic                     core_clk_o,
  output logic [N_PERIPH-1:0]      periph_clk_o,
  output logic [N_PDIV-1:0]        pdiv_clk_o,
  output logic                     clock_output_pin_o,
  output logic                     wdt_clk_o,
  output logic                     rtc_clk_o,
  output logic                     pll_pd_o,
  output logic [4:0]               pll_msel_o,
  output logic [1:0]               pll_loop_div_o,
  output logic                     sys_osc_en_o,
  output logic                     wdo_osc_en_o,
  output logic [3:0]               wdo_freq_o,
  output logic [1:0]               pwr_mode_o
);
  localparam int LW = $clog2(LOCK_CYC + 1);
  if (N_PERIPH < 1 || N_PERIPH > 32 || N_PDIV < 1 || N_PDIV > 4 || LOCK_CYC < 1) begin : g_chk
    $error("clock_gen_power_control: unsupported parameter values");
  end
  function automatic logic pick4(input logic [1:0] sel, input logic [3:0] lv);
    pick4 = lv[sel];
  endfunction
  // input synchronisers: three stages, change accepted when stages two and three agree
  logic [N_IN-1:0] s0_r, s1_r, s2_r, in_f_r, in_prev_r;
  always_ff @(posedge mclk_i) begin
    s0_r <= {wake_i, cco_osc_i, rtc_osc_i, wdo_osc_i, sys_osc_i, irc_osc_i};
    s1_r <= s0_r;
    s2_r <= s1_r;
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      in_f_r    <= '0;
      in_prev_r <= '0;
    end else begin
      for (int i = 0; i < N_IN; i++) begin
        if (s1_r[i] == s2_r[i]) in_f_r[i] <= s2_r[i];
      end
      in_prev_r <= in_f_r;
    end
  end
  logic cco_rise, wake_rise;
  assign cco_rise  = in_f_r[IN_CCO] & ~in_prev_r[IN_CCO];
  assign wake_rise = in_f_r[IN_WAKE] & ~in_prev_r[IN_WAKE];

  // software registers
  logic [1:0]          main_sel_r, clock_output_pin_sel_r;
  logic                pll_ref_r, wdt_sel_r, clock_output_pin_en_r;
  logic [4:0]          msel_r;
  logic [1:0]          psel_r;
  logic                pll_pd_r, pll_bypass_r;
  logic [7:0]          core_div_r;
  logic [N_PERIPH-1:0] periph_en_r;
  logic [7:0]          pdiv_r [N_PDIV];
  logic                sys_en_r, wdo_en_r;
  logic [3:0]          wdo_fq_r;
  pwr_mode_t           pm_r;
  logic                dpd_wake, wr_pll;
  assign dpd_wake = (pm_r == PM_DPD) && wake_rise;
  assign wr_pll   = wr_i && (addr_i == OFF_PLL_CTRL);
  always_ff @(posedge mclk_i) begin
    if (srst_i || dpd_wake) begin
      main_sel_r <= SRC_IRC;
    end else if (wr_i && addr_i == OFF_MAIN_SEL) begin
      main_sel_r <= wdata_i[1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i || dpd_wake) begin
      msel_r       <= MSEL_RST;
      psel_r       <= PSEL_RST;
      pll_pd_r     <= 1'b1;
      pll_bypass_r <= 1'b1;
    end else if (wr_pll) begin
      msel_r       <= wdata_i[PLL_MSEL_LSB +: 5];
      psel_r       <= wdata_i[PLL_PSEL_LSB +: 2];
      pll_pd_r     <= ~wdata_i[PLL_PU_BIT];
      pll_bypass_r <= wdata_i[PLL_BYP_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pll_ref_r    <= 1'b0;
      wdt_sel_r    <= 1'b0;
      clock_output_pin_sel_r <= SRC_IRC;
      clock_output_pin_en_r  <= 1'b0;
      core_div_r   <= CORE_DIV_RST;
      periph_en_r  <= '0;
      sys_en_r     <= 1'b0;
      wdo_en_r     <= 1'b0;
      wdo_fq_r     <= WDO_FQ_RST;
      for (int i = 0; i < N_PDIV; i++) pdiv_r[i] <= PDIV_RST;
    end else if (wr_i) begin
      case (addr_i)
        OFF_PLL_REF:   pll_ref_r <= wdata_i[0];
        OFF_WDT_SEL:   wdt_sel_r <= wdata_i[0];
        OFF_CLOCK_OUTPUT_PIN: begin
          clock_output_pin_sel_r <= wdata_i[1:0];
          clock_output_pin_en_r  <= wdata_i[CLOCK_OUTPUT_PIN_EN_BIT];
        end
        OFF_CORE_DIV:  core_div_r <= wdata_i[7:0];
        OFF_PERIPH_EN: periph_en_r <= wdata_i[N_PERIPH-1:0];
        OFF_PERIPH_DIV: begin
          for (int i = 0; i < N_PDIV; i++) pdiv_r[i] <= wdata_i[i*PDIV1_LSB +: 8];
        end
        OFF_OSC: begin
          sys_en_r <= wdata_i[OSC_SYS_EN_BIT];
          wdo_en_r <= wdata_i[OSC_WDO_EN_BIT];
          wdo_fq_r <= wdata_i[OSC_WDO_FQ_LSB +: 4];
        end
        default: ;
      endcase
    end
  end
  // power modes: a write enters a reduced state, a wake edge returns to active
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pm_r <= PM_ACTIVE;
    end else if (pm_r != PM_ACTIVE) begin
      if (wake_rise) pm_r <= PM_ACTIVE;
    end else if (wr_i && addr_i == OFF_PWR) begin
      pm_r <= pwr_mode_t'(wdata_i[1:0]);
    end
  end
  // pll lock timer
  logic [LW-1:0] lock_cnt_r;
  logic          pll_locked_r;
  always_ff @(posedge mclk_i) begin
    if (srst_i || pll_pd_r || wr_pll) begin
      lock_cnt_r   <= '0;
      pll_locked_r <= 1'b0;
    end else if (!pll_locked_r) begin
      if (lock_cnt_r == LW'(LOCK_CYC - 1)) pll_locked_r <= 1'b1;
      else lock_cnt_r <= lock_cnt_r + 1'b1;
    end
  end
  // post divider on the oscillator: toggle every 2**psel edges, so ratio is 2..16
  logic [3:0] pd_cnt_r;
  logic       pll_div_r;
  logic [3:0] pd_half;
  assign pd_half = 4'(4'h1 << psel_r) - 4'h1;
  always_ff @(posedge mclk_i) begin
    if (srst_i || pll_pd_r) begin
      pd_cnt_r  <= '0;
      pll_div_r <= 1'b0;
    end else if (cco_rise) begin
      if (pd_cnt_r >= pd_half) begin
        pd_cnt_r  <= '0;
        pll_div_r <= ~pll_div_r;
      end else begin
        pd_cnt_r <= pd_cnt_r + 4'h1;
      end
    end
  end
  logic ref_lvl, pll_lvl;
  logic [3:0] src_lv;
  assign ref_lvl = pll_ref_r ? in_f_r[IN_SYS] : in_f_r[IN_IRC];
  assign pll_lvl = (pll_bypass_r || pll_pd_r) ? ref_lvl : pll_div_r;
  // rtc oscillator is deliberately absent from every selector
  assign src_lv  = {pll_lvl, in_f_r[IN_WDO], in_f_r[IN_SYS], in_f_r[IN_IRC]};
  // glitch-free main clock switch
  sw_state_t sw_r;
  logic [1:0] cur_src_r;
  logic       main_lvl_r;
  logic       cur_lvl;
  assign cur_lvl = pick4(cur_src_r, src_lv);
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sw_r       <= SW_RUN;
      cur_src_r  <= SRC_IRC;
      main_lvl_r <= 1'b0;
    end else begin
      case (sw_r)
        SW_RUN: begin
          main_lvl_r <= cur_lvl;
          if (main_sel_r != cur_src_r) sw_r <= SW_OFF_WAIT;
        end
        SW_OFF_WAIT: begin
          if (!cur_lvl) begin
            main_lvl_r <= 1'b0;
            cur_src_r  <= main_sel_r;
            sw_r       <= SW_ON_WAIT;
          end
        end
        SW_ON_WAIT: begin
          main_lvl_r <= 1'b0;
          if (!cur_lvl) sw_r <= SW_RUN;
        end
        default: sw_r <= SW_RUN;
      endcase
    end
  end

  logic main_rise, main_prev_r, main_run;
  always_ff @(posedge mclk_i) begin
    if (srst_i) main_prev_r <= 1'b0;
    else main_prev_r <= main_lvl_r;
  end
  assign main_rise = main_lvl_r & ~main_prev_r;
  // deep sleep and deep power-down stop the peripheral and divided clocks derived from the main clock
  assign main_run  = (pm_r == PM_ACTIVE) || (pm_r == PM_SLEEP);

  // core clock: toggles every core_div main edges; zero stops it
  logic [7:0] core_cnt_r;
  logic       core_tgl_r, core_run_r;
  always_ff @(posedge mclk_i) begin
    if (srst_i || core_div_r == 8'h00) begin
      core_cnt_r <= '0;
      core_tgl_r <= 1'b0;
    end else if (main_rise) begin
      if (core_cnt_r >= core_div_r - 8'h01) begin
        core_cnt_r <= '0;
        core_tgl_r <= ~core_tgl_r;
      end else begin
        core_cnt_r <= core_cnt_r + 8'h01;
      end
    end
  end
  // gate changes only while the divided clock is low
  always_ff @(posedge mclk_i) begin
    if (srst_i) core_run_r <= 1'b1;
    else if (!core_tgl_r) core_run_r <= (pm_r == PM_ACTIVE);
  end
  // per-peripheral dividers
  logic [7:0]        pdiv_cnt_r [N_PDIV];
  logic [N_PDIV-1:0] pdiv_tgl_r;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pdiv_tgl_r <= '0;
      for (int i = 0; i < N_PDIV; i++) pdiv_cnt_r[i] <= '0;
    end else if (main_rise) begin
      for (int i = 0; i < N_PDIV; i++) begin
        if (pdiv_r[i] == 8'h00) begin
          pdiv_cnt_r[i] <= '0;
          pdiv_tgl_r[i] <= 1'b0;
        end else if (pdiv_cnt_r[i] >= pdiv_r[i] - 8'h01) begin
          pdiv_cnt_r[i] <= '0;
          pdiv_tgl_r[i] <= ~pdiv_tgl_r[i];
        end else begin
          pdiv_cnt_r[i] <= pdiv_cnt_r[i] + 8'h01;
        end
      end
    end
  end
  // output flops
  logic [3:0] co_lv;
  assign co_lv = {main_lvl_r, in_f_r[IN_WDO], in_f_r[IN_SYS], in_f_r[IN_IRC]};
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      core_clk_o   <= 1'b0;
      periph_clk_o <= '0;
      pdiv_clk_o   <= '0;
      clock_output_pin_o     <= 1'b0;
      wdt_clk_o    <= 1'b0;
      rtc_clk_o    <= 1'b0;
      pll_pd_o       <= 1'b1;
      pll_msel_o     <= MSEL_RST;
      pll_loop_div_o <= PSEL_RST;
      sys_osc_en_o   <= 1'b0;
      wdo_osc_en_o   <= 1'b0;
      wdo_freq_o     <= WDO_FQ_RST;
      pwr_mode_o     <= PM_ACTIVE;
    end else begin
      core_clk_o   <= core_tgl_r & core_run_r;
      periph_clk_o <= periph_en_r & {N_PERIPH{main_lvl_r & main_run}};
      pdiv_clk_o   <= pdiv_tgl_r & {N_PDIV{main_run}};
      clock_output_pin_o     <= clock_output_pin_en_r & pick4(clock_output_pin_sel_r, co_lv);
      wdt_clk_o    <= wdt_sel_r ? in_f_r[IN_WDO] : in_f_r[IN_IRC];
      rtc_clk_o    <= in_f_r[IN_RTC];
      pll_pd_o       <= pll_pd_r;
      pll_msel_o     <= msel_r;
      pll_loop_div_o <= psel_r;
      sys_osc_en_o   <= sys_en_r;
      wdo_osc_en_o   <= wdo_en_r;
      wdo_freq_o     <= wdo_fq_r;
      pwr_mode_o     <= pm_r;
    end
  end
  // register read, data one cycle after the strobe
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (addr_i)
      OFF_MAIN_SEL:   rd_val[1:0] = main_sel_r;
      OFF_PLL_REF:    rd_val[0] = pll_ref_r;
      OFF_PLL_CTRL: begin
        rd_val[PLL_MSEL_LSB +: 5] = msel_r;
        rd_val[PLL_PSEL_LSB +: 2] = psel_r;
        rd_val[PLL_PU_BIT]        = ~pll_pd_r;
        rd_val[PLL_BYP_BIT]       = pll_bypass_r;
      end
      OFF_PLL_STAT:   rd_val[0] = pll_locked_r;
      OFF_CORE_DIV:   rd_val[7:0] = core_div_r;
      OFF_PERIPH_EN:  rd_val[N_PERIPH-1:0] = periph_en_r;
      OFF_PERIPH_DIV: for (int i = 0; i < N_PDIV; i++) rd_val[i*PDIV1_LSB +: 8] = pdiv_r[i];
      OFF_CLOCK_OUTPUT_PIN: begin
        rd_val[1:0]           = clock_output_pin_sel_r;
        rd_val[CLOCK_OUTPUT_PIN_EN_BIT] = clock_output_pin_en_r;
      end
      OFF_WDT_SEL:    rd_val[0] = wdt_sel_r;
      OFF_PWR:        rd_val[1:0] = pm_r;
      OFF_OSC: begin
        rd_val[OSC_SYS_EN_BIT]      = sys_en_r;
        rd_val[OSC_WDO_EN_BIT]      = wdo_en_r;
        rd_val[OSC_WDO_FQ_LSB +: 4] = wdo_fq_r;
      end
      OFF_STATUS: begin
        rd_val[1:0]               = cur_src_r;
        rd_val[STAT_BUSY_BIT]     = (sw_r != SW_RUN);
        rd_val[STAT_MODE_LSB +: 2] = pm_r;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) rdata_o <= 32'h0000_0000;
    else rdata_o <= rd_i ? rd_val : 32'h0000_0000;
  end
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  reset_source_a: assert property ($past(srst_i) |-> main_sel_r == SRC_IRC && cur_src_r == SRC_IRC)
    else $error("main clock not on RC oscillator after reset");
  pll_reset_a: assert property ($past(srst_i) |-> pll_pd_o && pll_pd_r && pll_bypass_r)
    else $error("pll not off and bypassed after reset");
  lock_early_a: assert property (!pll_pd_r && lock_cnt_r < LW'(LOCK_CYC - 1) |-> !pll_locked_r)
    else $error("pll lock reported before settling time");
  lock_drop_a: assert property (pll_pd_r || wr_pll |=> !pll_locked_r && lock_cnt_r == '0)
    else $error("pll lock not cleared on power-down or reconfigure");
  postdiv_edge_a: assert property ($changed(pll_div_r) && !$past(pll_pd_r) |-> $past(cco_rise) && $past(pd_cnt_r) == $past(pd_half))
    else $error("post divider toggled off its half period");
  switch_low_a: assert property (sw_r == SW_ON_WAIT |-> !main_lvl_r)
    else $error("main clock high during source changeover");
  switch_rise_a: assert property ($rose(main_lvl_r) |-> $past(sw_r) == SW_RUN)
    else $error("main clock rose outside run state");
  sleep_core_a: assert property (pm_r != PM_ACTIVE && !core_tgl_r ##1 pm_r != PM_ACTIVE |=> !core_clk_o)
    else $error("core clock running in reduced power mode");
  periph_gate_a: assert property ((periph_clk_o & ~$past(periph_en_r)) == '0)
    else $error("clock reaches a disabled peripheral");
  dpd_wake_a: assert property (dpd_wake |=> main_sel_r == SRC_IRC && pll_pd_r && pm_r == PM_ACTIVE)
    else $error("deep power-down wake did not restart on RC oscillator");

  pll_lock_c:    cover property ($rose(pll_locked_r));
  pll_switch_c:  cover property (sw_r == SW_ON_WAIT ##[1:50] sw_r == SW_RUN && cur_src_r == SRC_PLL);
  sleep_wake_c:  cover property (pm_r == PM_SLEEP ##1 pm_r == PM_ACTIVE);
  dpd_wake_c:    cover property (dpd_wake);
endmodule

// ===== core/clkpwr_pkg.sv
// constants and types for the clock generation and power control block
package clkpwr_pkg;
  // timing
  localparam int CLK_MHZ        = 100;
  localparam int PLL_SETTLE_US  = 100;
  localparam int PLL_SETTLE_CYC = PLL_SETTLE_US * CLK_MHZ;
  // register byte offsets
  localparam logic [7:0] OFF_MAIN_SEL   = 8'h00;
  localparam logic [7:0] OFF_PLL_REF    = 8'h04;
  localparam logic [7:0] OFF_PLL_CTRL   = 8'h08;
  localparam logic [7:0] OFF_PLL_STAT   = 8'h0c;
  localparam logic [7:0] OFF_CORE_DIV   = 8'h10;
  localparam logic [7:0] OFF_PERIPH_EN  = 8'h14;
  localparam logic [7:0] OFF_PERIPH_DIV = 8'h18;
  localparam logic [7:0] OFF_CLOCK_OUTPUT_PIN     = 8'h1c;
  localparam logic [7:0] OFF_WDT_SEL    = 8'h20;
  localparam logic [7:0] OFF_PWR        = 8'h24;
  localparam logic [7:0] OFF_OSC        = 8'h28;
  localparam logic [7:0] OFF_STATUS     = 8'h2c;
  // main clock and clock output source codes
  localparam logic [1:0] SRC_IRC  = 2'h0;
  localparam logic [1:0] SRC_SYS  = 2'h1;
  localparam logic [1:0] SRC_WDO  = 2'h2;
  localparam logic [1:0] SRC_PLL  = 2'h3;
  localparam logic [1:0] SRC_MAIN = 2'h3;
  // field positions
  localparam int PLL_MSEL_LSB   = 0;
  localparam int PLL_PSEL_LSB   = 5;
  localparam int PLL_PU_BIT     = 8;
  localparam int PLL_BYP_BIT    = 9;
  localparam int PDIV1_LSB      = 8;
  localparam int CLOCK_OUTPUT_PIN_EN_BIT  = 8;
  localparam int OSC_SYS_EN_BIT = 0;
  localparam int OSC_WDO_EN_BIT = 1;
  localparam int OSC_WDO_FQ_LSB = 4;
  localparam int STAT_BUSY_BIT  = 2;
  localparam int STAT_MODE_LSB  = 4;
  // reset values
  localparam logic [4:0] MSEL_RST     = 5'h00;
  localparam logic [1:0] PSEL_RST     = 2'h0;
  localparam logic [7:0] CORE_DIV_RST = 8'h01;
  localparam logic [7:0] PDIV_RST     = 8'h01;
  localparam logic [3:0] WDO_FQ_RST   = 4'h0;
  // synchronised input slots
  localparam int IN_IRC  = 0;
  localparam int IN_SYS  = 1;
  localparam int IN_WDO  = 2;
  localparam int IN_RTC  = 3;
  localparam int IN_CCO  = 4;
  localparam int IN_WAKE = 5;
  localparam int N_IN    = 6;

  typedef enum logic [1:0] {PM_ACTIVE, PM_SLEEP, PM_DEEP_SLEEP, PM_DPD} pwr_mode_t;
  typedef enum logic [1:0] {SW_RUN, SW_OFF_WAIT, SW_ON_WAIT} sw_state_t;
endpackage

// ===== verification/tb.sv
// self-checking bench for the clock generation and power control block
`timescale 1ns/1ps
module tb;
  import clkpwr_pkg::*;
  localparam int LCK = 20;
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        irc_osc_i = 1'b0, sys_osc_i = 1'b0, wdo_osc_i = 1'b0;
  logic        rtc_osc_i = 1'b0, cco_osc_i = 1'b0, wake_i = 1'b0;
  logic [31:0] rdata_o;
  logic        core_clk_o, clock_output_pin_o, wdt_clk_o, rtc_clk_o, pll_pd_o;
  logic        sys_osc_en_o, wdo_osc_en_o;
  logic [15:0] periph_clk_o;
  logic [1:0]  pdiv_clk_o, pll_loop_div_o, pwr_mode_o;
  logic [4:0]  pll_msel_o;
  logic [3:0]  wdo_freq_o;
  int          fails = 0;
  int          checks = 0;
  int          cyc = 0;
  int          cnt[7];
  logic [6:0]  prv = '0;
  logic [15:0] pseen;
  logic [1:0]  dseen;
  logic [31:0] q, d;
  int          regm[int];

  clock_gen_power_control #(.LOCK_CYC(LCK)) dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irc_osc_i(irc_osc_i), .sys_osc_i(sys_osc_i),
    .wdo_osc_i(wdo_osc_i), .rtc_osc_i(rtc_osc_i), .cco_osc_i(cco_osc_i), .wake_i(wake_i),
    .core_clk_o(core_clk_o), .periph_clk_o(periph_clk_o), .pdiv_clk_o(pdiv_clk_o),
    .clock_output_pin_o(clock_output_pin_o), .wdt_clk_o(wdt_clk_o), .rtc_clk_o(rtc_clk_o), .pll_pd_o(pll_pd_o),
    .pll_msel_o(pll_msel_o), .pll_loop_div_o(pll_loop_div_o), .sys_osc_en_o(sys_osc_en_o),
    .wdo_osc_en_o(wdo_osc_en_o), .wdo_freq_o(wdo_freq_o), .pwr_mode_o(pwr_mode_o));

  always #5 mclk_i = ~mclk_i;

  // oscillator levels: periods of 8, 10, 14, 18 and 6 system cycles
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    irc_osc_i <= (cyc % 8) < 4;
    sys_osc_i <= (cyc % 10) < 5;
    wdo_osc_i <= (cyc % 14) < 7;
    rtc_osc_i <= (cyc % 18) < 9;
    cco_osc_i <= (cyc % 6) < 3;
  end

  // rising edge counts: 6 core, 5 clock_output_pin, 4 wdt, 3 rtc, 2 irc, 1 sys, 0 wdo
  always @(posedge mclk_i) begin
    logic [6:0] s;
    s = {core_clk_o, clock_output_pin_o, wdt_clk_o, rtc_clk_o, irc_osc_i, sys_osc_i, wdo_osc_i};
    for (int i = 0; i < 7; i++) begin
      if (s[i] && !prv[i]) cnt[i]++;
    end
    prv <= s;
    pseen |= periph_clk_o;
    dseen |= pdiv_clk_o;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask

  task automatic win(input int n);
    #1;
    for (int i = 0; i < 7; i++) cnt[i] = 0;
    pseen = '0;
    dseen = '0;
    repeat (n) @(posedge mclk_i);
  endtask

  function automatic logic [31:0] near(input int a, input int b, input int t);
    return {31'h0, (a - b <= t) && (b - a <= t)};
  endfunction

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    results();
  end

  initial begin
    logic [7:0]  offs[6];
    logic [31:0] msks[6];
    logic [4:0]  ms[4];
    logic [1:0]  srcs[4];
    offs = '{OFF_PLL_REF, OFF_CORE_DIV, OFF_PERIPH_DIV, OFF_CLOCK_OUTPUT_PIN, OFF_WDT_SEL, OFF_OSC};
    msks = '{32'h1, 32'hff, 32'hffff, 32'h103, 32'h1, 32'hf3};
    ms = '{5'h00, 5'h1f, 5'h0a, 5'h13};
    srcs = '{SRC_SYS, SRC_WDO, SRC_PLL, SRC_IRC};
    void'($urandom(32'hc91e7d0f));
    repeat (16) @(posedge mclk_i);
    srst_i <= 1'b0;
    check({31'h0, pll_pd_o}, 32'h1);
    rd(OFF_PLL_CTRL, q);
    check(q & 32'h300, 32'h200);
    rd(OFF_MAIN_SEL, q);
    check(q, 32'h0);
    win(80);
    check(near(cnt[6] * 2, cnt[2], 3), 32'h1);
    check({16'h0, pseen}, 32'h0);
    $display("test reset done");

    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      regm[offs[i]] = d & msks[i];
      wr(offs[i], d);
    end
    for (int i = 0; i < 6; i++) begin
      rd(offs[i], q);
      check(q, regm[offs[i]]);
    end
    check({31'h0, sys_osc_en_o}, {31'h0, d[0]});
    check({31'h0, wdo_osc_en_o}, {31'h0, d[1]});
    check({28'h0, wdo_freq_o}, {28'h0, d[7:4]});
    wr(8'h30, 32'hffffffff);
    rd(8'h30, q);
    check(q, 32'h0);
    $display("test registers done");

    wr(OFF_OSC, 32'h3);
    wr(OFF_PLL_REF, 32'h0);
    for (int p = 0; p < 4; p++) begin
      wr(OFF_PLL_CTRL, 32'h100 | (p << PLL_PSEL_LSB) | ms[p]);
      @(posedge mclk_i);
      #1;
      check({27'h0, pll_msel_o}, {27'h0, ms[p]});
      check({30'h0, pll_loop_div_o}, p);
      check({31'h0, pll_pd_o}, 32'h0);
      rd(OFF_PLL_STAT, q);
      check(q & 32'h1, 32'h0);
    end
    repeat (LCK + 6) @(posedge mclk_i);
    rd(OFF_PLL_STAT, q);
    check(q & 32'h1, 32'h1);
    wr(OFF_PLL_CTRL, 32'h00f);
    @(posedge mclk_i);
    #1;
    check({31'h0, pll_pd_o}, 32'h1);
    rd(OFF_PLL_STAT, q);
    check(q & 32'h1, 32'h0);
    wr(OFF_PLL_CTRL, 32'h10f);
    repeat (LCK / 2) @(posedge mclk_i);
    rd(OFF_PLL_STAT, q);
    check(q & 32'h1, 32'h0);
    repeat (LCK) @(posedge mclk_i);
    rd(OFF_PLL_STAT, q);
    check(q & 32'h1, 32'h1);
    $display("test pll done");

    for (int i = 0; i < 4; i++) begin
      wr(OFF_MAIN_SEL, srcs[i]);
      repeat (80) @(posedge mclk_i);
      rd(OFF_STATUS, q);
      check(q & 32'h7, srcs[i]);
    end
    $display("test main select done");

    for (int s = 0; s < 4; s++) begin
      wr(OFF_CLOCK_OUTPUT_PIN, 32'h100 | s);
      win(20);
      win(160);
      check(near(cnt[5], cnt[2 - (s % 3)], 1), 32'h1);
    end
    wr(OFF_CLOCK_OUTPUT_PIN, 32'h0);
    win(20);
    win(100);
    check(cnt[5], 32'h0);
    for (int w = 0; w < 2; w++) begin
      wr(OFF_WDT_SEL, w);
      win(20);
      win(160);
      check(near(cnt[4], cnt[w ? 0 : 2], 1), 32'h1);
      check(near(cnt[3], 9, 1), 32'h1);
    end
    $display("test clock routing done");

    for (int n = 0; n < 3; n++) begin
      wr(OFF_CORE_DIV, n);
      win(40);
      win(240);
      check(near(cnt[6] * 2 * (n ? n : 1), n ? cnt[2] : 0, 2 * n + 1), 32'h1);
    end
    wr(OFF_CORE_DIV, 32'h1);
    d = $urandom & 32'hffff;
    wr(OFF_PERIPH_EN, d);
    wr(OFF_PERIPH_DIV, 32'h0102);
    win(20);
    win(120);
    check({16'h0, pseen}, d);
    check({30'h0, dseen}, 32'h3);
    wr(OFF_PERIPH_DIV, 32'h0100);
    win(20);
    win(120);
    check({30'h0, dseen}, 32'h2);
    $display("test gating done");

    wr(OFF_PERIPH_EN, 32'hffff);
    wr(OFF_PERIPH_DIV, 32'h0101);
    for (int m = 1; m < 4; m++) begin
      if (m == 3) wr(OFF_MAIN_SEL, SRC_SYS);
      if (m == 3) repeat (60) @(posedge mclk_i);
      wr(OFF_PWR, m);
      win(20);
      check({30'h0, pwr_mode_o}, m);
      wr(OFF_PWR, 32'h1);
      rd(OFF_STATUS, q);
      check((q >> STAT_MODE_LSB) & 32'h3, m);
      win(100);
      check(cnt[6], 32'h0);
      check({16'h0, pseen}, (m == 1) ? 32'hffff : 32'h0);
      check({30'h0, dseen}, (m == 1) ? 32'h3 : 32'h0);
      @(posedge mclk_i);
      wake_i <= 1'b1;
      repeat (10) @(posedge mclk_i);
      wake_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      check({30'h0, pwr_mode_o}, 32'h0);
    end
    rd(OFF_MAIN_SEL, q);
    check(q, SRC_IRC);
    rd(OFF_PLL_CTRL, q);
    check(q & 32'h300, 32'h200);
    check({31'h0, pll_pd_o}, 32'h1);
    win(80);
    check(near(cnt[6] * 2, cnt[2], 3), 32'h1);
    $display("test power done");
    results();
  end
endmodule
